// [src/tmc_pkg.sv]
package tmc_pkg;

    // ****************************************
    // Timing and sizes
    // ****************************************
    localparam int TMC_START_DELAY = 4; // Cycles from frame-available to first read
    localparam int TMC_IFG_CYCLES = 12; // Idle bytes between frames
    localparam int TMC_PAUSE_LEN = 60; // Pause frame length in bytes, before FCS
    localparam int TMC_FIFO_DEPTH = 4; // Staging FIFO depth in words
    localparam int TMC_CNT_W = 14; // Byte counter width
    localparam logic [13:0] TMC_CNT_RST = 14'h0000; // Byte counter reset value
    localparam logic [30:0] TMC_STAT_RST = 31'h00000000; // Statistics reset value

    // ****************************************
    // Statistics vector field positions
    // ****************************************
    localparam int TMC_ST_UNDERRUN = 5;
    localparam int TMC_ST_PAUSE = 6;
    localparam int TMC_ST_LEN_LO = 8;
    localparam int TMC_ST_LATECOL = 24;
    localparam int TMC_ST_EXCOL = 25;

    // ****************************************
    // Pause frame constant bytes
    // ****************************************
    localparam logic [15:0] TMC_PAUSE_TYPE = 16'h8808;
    localparam logic [15:0] TMC_PAUSE_OPC = 16'h0001;

    // Byte on the network side, with end mark and error
    typedef struct packed {
        logic [7:0] data;
        logic last;
        logic err;
    } tmc_byte_s;

    // Transmit sequencer states
    typedef enum logic [2:0] {
        TMC_IDLE,
        TMC_WAIT,
        TMC_DATA,
        TMC_PAUSE,
        TMC_END,
        TMC_GAP
    } tmc_state_e;

endpackage

// [src/tmc_fifo.sv]
`timescale 1ns/1ps
module tmc_fifo import tmc_pkg::*; #(
    parameter int WIDTH = 10,
    parameter int DEPTH = 4
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic [WIDTH-1:0] inData,
    input wire logic inValid,
    output logic inReady,
    output logic [WIDTH-1:0] outData,
    output logic outValid,
    input wire logic outReady
);
    // ****************************************
    // Storage and pointers
    // ****************************************
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH]; // Word store
    logic [AW-1:0] wrPtr_reg, wrPtr_next; // Write pointer
    logic [AW-1:0] rdPtr_reg, rdPtr_next; // Read pointer
    logic [AW:0] count_reg, count_next; // Occupancy
    logic doWrite, doRead;

    // Honest full and empty straight from occupancy
    assign inReady = (count_reg != (AW+1)'(DEPTH));
    assign outValid = (count_reg != '0);
    assign outData = mem[rdPtr_reg];
    assign doWrite = inValid && inReady;
    assign doRead = outValid && outReady;

    // Next pointer values
    always_comb begin
        wrPtr_next = wrPtr_reg;
        rdPtr_next = rdPtr_reg;
        count_next = count_reg;
        if (doWrite) begin
            wrPtr_next = (wrPtr_reg == AW'(DEPTH-1)) ? '0 : wrPtr_reg + 1'b1;
        end
        if (doRead) begin
            rdPtr_next = (rdPtr_reg == AW'(DEPTH-1)) ? '0 : rdPtr_reg + 1'b1;
        end
        if (doWrite && !doRead) begin
            count_next = count_reg + 1'b1;
        end else if (doRead && !doWrite) begin
            count_next = count_reg - 1'b1;
        end
    end

    // Register pointers; memory has no reset
    always_ff @(posedge clock) begin
        if (rst) begin
            wrPtr_reg <= '0;
            rdPtr_reg <= '0;
            count_reg <= '0;
        end else begin
            wrPtr_reg <= wrPtr_next;
            rdPtr_reg <= rdPtr_next;
            count_reg <= count_next;
        end
        if (doWrite) begin
            mem[wrPtr_reg] <= inData;
        end
    end
endmodule

// [src/tmc_tx_client.sv]
`timescale 1ns/1ps
// Operation
// - Transmission starts shortly after frame-available
// - Empty while reading means underrun, raise error
// - Pause request sends a pause frame
// - Pause time held valid with request
// - Control flag qualified by frame-available
// - Statistics enable only with valid vector
// - Read request marks each intended byte read
// - First read only when FIFO not empty
// - Later reads only while not empty
// - Done pulses one cycle on clean frame
// - Discard on underrun, or on collision errors in half duplex
module tmc_tx_client import tmc_pkg::*; #(
    parameter int START_DELAY = TMC_START_DELAY,
    parameter int IFG_CYCLES = TMC_IFG_CYCLES,
    parameter int FIFO_DEPTH = TMC_FIFO_DEPTH
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic clockEn,
    input wire logic halfDuplex,
    input wire logic [7:0] fifoData,
    input wire logic fifoAvail,
    input wire logic fifoEof,
    input wire logic fifoEmpty,
    input wire logic fifoCtrl,
    input wire logic [15:0] pauseTime,
    input wire logic pauseReq,
    input wire logic lateCollision,
    input wire logic excessCollision,
    output logic macRead,
    output logic [7:0] txData,
    output logic txEn,
    output logic txErr,
    input wire logic txReady,
    output logic [30:0] statVec,
    output logic statEn,
    output logic txDone,
    output logic discardFrame
);
    // ****************************************
    // State declarations
    // ****************************************
    tmc_state_e state_reg, state_next; // Sequencer state
    logic [TMC_CNT_W-1:0] cnt_reg, cnt_next; // Wait, byte and gap counter
    logic readPend_reg, readPend_next; // A read was issued last enabled cycle
    logic underrun_reg, underrun_next; // Underrun seen in this frame
    logic isPause_reg, isPause_next; // Current frame is a pause frame
    logic isCtrl_reg, isCtrl_next; // Current frame marked control
    logic [15:0] pauseVal_reg, pauseVal_next; // Captured pause time
    logic pausePend_reg, pausePend_next; // Pause request waiting
    logic [30:0] statVec_reg, statVec_next; // Statistics vector
    logic statEn_reg, statEn_next; // Statistics strobe
    logic txDone_reg, txDone_next; // Clean frame pulse
    logic discard_reg, discard_next; // Bad frame pulse
    logic collErr; // Collision error that counts in half duplex only

    // ****************************************
    // Staging FIFO toward the network side
    // ****************************************
    tmc_byte_s pushByte, popByte; // Byte entering and leaving
    logic pushValid, pushReady, popValid; // FIFO handshakes

    tmc_fifo #(
        .WIDTH($bits(tmc_byte_s)),
        .DEPTH(FIFO_DEPTH)
    ) u_stage (
        .clock(clock),
        .rst(rst),
        .inData(pushByte),
        .inValid(pushValid),
        .inReady(pushReady),
        .outData(popByte),
        .outValid(popValid),
        .outReady(txReady)
    );

    // Network side drains the staging FIFO; stall comes from txReady
    assign txEn = popValid;
    assign txData = popByte.data;
    assign txErr = popValid && popByte.err;

    // Collisions only count against the frame in half duplex
    assign collErr = halfDuplex && (lateCollision || excessCollision);

    // Outputs taken from registers
    assign statVec = statVec_reg;
    assign statEn = statEn_reg;
    assign txDone = txDone_reg;
    assign discardFrame = discard_reg;

    // Pause byte generator: type, opcode, time, then zero padding
    function automatic logic [7:0] pauseByte(input logic [TMC_CNT_W-1:0] idx,
                                             input logic [15:0] tim);
        logic [7:0] b;
        b = 8'h00;
        case (idx)
            14'd0: b = TMC_PAUSE_TYPE[15:8];
            14'd1: b = TMC_PAUSE_TYPE[7:0];
            14'd2: b = TMC_PAUSE_OPC[15:8];
            14'd3: b = TMC_PAUSE_OPC[7:0];
            14'd4: b = tim[15:8];
            14'd5: b = tim[7:0];
            default: b = 8'h00;
        endcase
        return b;
    endfunction

    // ****************************************
    // Sequencer next state
    // ****************************************
    always_comb begin
        state_next = state_reg;
        cnt_next = cnt_reg;
        readPend_next = readPend_reg;
        underrun_next = underrun_reg;
        isPause_next = isPause_reg;
        isCtrl_next = isCtrl_reg;
        pauseVal_next = pauseVal_reg;
        pausePend_next = pausePend_reg;
        statVec_next = statVec_reg;
        statEn_next = 1'b0;
        txDone_next = 1'b0;
        discard_next = 1'b0;
        macRead = 1'b0;
        pushValid = 1'b0;
        pushByte = '0;
        // Latch a pause request with its time
        if (pauseReq && !pausePend_reg) begin
            pausePend_next = 1'b1;
            pauseVal_next = pauseTime;
        end
        // Everything else in the sequencer paced by the byte clock enable
        if (clockEn) begin
            case (state_reg)
                // Idle: pause first, then waiting frames
                TMC_IDLE: begin
                    cnt_next = TMC_CNT_RST;
                    underrun_next = 1'b0;
                    if (pausePend_reg) begin
                        isPause_next = 1'b1;
                        state_next = TMC_PAUSE;
                    end else if (fifoAvail) begin
                        isPause_next = 1'b0;
                        isCtrl_next = fifoCtrl;
                        state_next = TMC_WAIT;
                    end
                end
                // Short delay before the first read
                TMC_WAIT: begin
                    if (cnt_reg >= TMC_CNT_W'(START_DELAY - 1) && !fifoEmpty) begin
                        macRead = pushReady;
                        if (pushReady) begin
                            readPend_next = 1'b1;
                            cnt_next = TMC_CNT_RST;
                            state_next = TMC_DATA;
                        end
                    end else if (cnt_reg < TMC_CNT_W'(START_DELAY - 1)) begin
                        cnt_next = cnt_reg + 1'b1;
                    end
                end
                // Stream bytes: capture one cycle after each read
                TMC_DATA: begin
                    readPend_next = 1'b0;
                    if (readPend_reg) begin
                        pushValid = 1'b1;
                        pushByte.data = fifoData;
                        pushByte.last = fifoEof;
                        cnt_next = cnt_reg + 1'b1;
                    end
                    if (readPend_reg && fifoEof) begin
                        state_next = TMC_END;
                    end else if (fifoEmpty && (readPend_reg || pushReady)) begin
                        // Reading ran dry inside a frame
                        pushValid = 1'b1;
                        pushByte.err = 1'b1;
                        pushByte.last = 1'b1;
                        underrun_next = 1'b1;
                        state_next = TMC_END;
                    end else if (!readPend_reg && pushReady) begin
                        // Read only on a free cycle, so the byte always finds room
                        macRead = 1'b1;
                        readPend_next = 1'b1;
                    end
                end
                // Pause frame built locally
                TMC_PAUSE: begin
                    if (pushReady) begin
                        pushValid = 1'b1;
                        pushByte.data = pauseByte(cnt_reg, pauseVal_reg);
                        pushByte.last = (cnt_reg == TMC_CNT_W'(TMC_PAUSE_LEN - 1));
                        cnt_next = cnt_reg + 1'b1;
                        if (pushByte.last) begin
                            cnt_next = TMC_CNT_W'(TMC_PAUSE_LEN);
                            pausePend_next = 1'b0;
                            state_next = TMC_END;
                        end
                    end
                end
                // Close the frame: statistics and result pulses
                TMC_END: begin
                    statVec_next = TMC_STAT_RST;
                    statVec_next[TMC_ST_UNDERRUN] = underrun_reg;
                    statVec_next[TMC_ST_PAUSE] = isPause_reg;
                    statVec_next[TMC_ST_LEN_LO +: TMC_CNT_W] = cnt_reg;
                    statVec_next[TMC_ST_LATECOL] = halfDuplex && lateCollision;
                    statVec_next[TMC_ST_EXCOL] = halfDuplex && excessCollision;
                    statEn_next = 1'b1;
                    if (underrun_reg || collErr) begin
                        discard_next = 1'b1;
                    end else begin
                        txDone_next = 1'b1;
                    end
                    cnt_next = TMC_CNT_RST;
                    state_next = TMC_GAP;
                end
                // Interframe gap; pause request stays latched
                TMC_GAP: begin
                    if (cnt_reg >= TMC_CNT_W'(IFG_CYCLES - 1)) begin
                        state_next = TMC_IDLE;
                    end else begin
                        cnt_next = cnt_reg + 1'b1;
                    end
                end
                default: begin
                    state_next = TMC_IDLE;
                end
            endcase
        end
    end

    // ****************************************
    // Sequencer registers
    // ****************************************
    always_ff @(posedge clock) begin
        if (rst) begin
            state_reg <= TMC_IDLE;
            cnt_reg <= TMC_CNT_RST;
            readPend_reg <= 1'b0;
            underrun_reg <= 1'b0;
            isPause_reg <= 1'b0;
            isCtrl_reg <= 1'b0;
            pauseVal_reg <= 16'h0000;
            pausePend_reg <= 1'b0;
            statVec_reg <= TMC_STAT_RST;
            statEn_reg <= 1'b0;
            txDone_reg <= 1'b0;
            discard_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            cnt_reg <= cnt_next;
            readPend_reg <= readPend_next;
            underrun_reg <= underrun_next;
            isPause_reg <= isPause_next;
            isCtrl_reg <= isCtrl_next;
            pauseVal_reg <= pauseVal_next;
            pausePend_reg <= pausePend_next;
            statVec_reg <= statVec_next;
            statEn_reg <= statEn_next;
            txDone_reg <= txDone_next;
            discard_reg <= discard_next;
        end
    end
endmodule

// [dv/tmc_tx_client_checker.sv]
`timescale 1ns/1ps
// ****************************************
// Port checker for the transmit client side
// ****************************************
module tmc_tx_client_checker import tmc_pkg::*; (
    input wire logic clock,
    input wire logic rst,
    input wire logic fifoAvail,
    input wire logic fifoEmpty,
    input wire logic pauseReq,
    input wire logic macRead,
    input wire logic txEn,
    input wire logic [30:0] statVec,
    input wire logic statEn,
    input wire logic txDone,
    input wire logic discardFrame
);
    // One domain, so clock and reset are given once
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    AST_READ_NOT_EMPTY: assert property (macRead |-> !fifoEmpty)
        else $error("read request while client FIFO empty");
    AST_READ_ALTERNATE: assert property (macRead |=> !macRead)
        else $error("read request on two cycles in a row");
    // Wide bound covers the slowest clock enable pacing
    AST_START_SOON: assert property ($rose(fifoAvail) && !pauseReq |-> ##[1:200] macRead)
        else $error("frame not started after frame available");
    AST_PAUSE_SENDS: assert property ($rose(pauseReq) |-> ##[1:200] txEn)
        else $error("pause request sent nothing");
    AST_DONE_PULSE: assert property (txDone |=> !txDone)
        else $error("done longer than one cycle");
    AST_DONE_CLEAN: assert property (txDone |-> statEn && !statVec[TMC_ST_UNDERRUN])
        else $error("done without clean statistics");
    AST_UNDERRUN_DISC: assert property (statEn && statVec[TMC_ST_UNDERRUN] |-> discardFrame && !txDone)
        else $error("underrun frame not discarded");
    AST_DISC_STAT: assert property (discardFrame |-> statEn && !txDone)
        else $error("discard without statistics");
    AST_VEC_HELD: assert property ($changed(statVec) |-> statEn)
        else $error("statistics changed without enable");
endmodule
bind tmc_tx_client tmc_tx_client_checker chk (.clock(clock), .rst(rst), .fifoAvail(fifoAvail),
    .fifoEmpty(fifoEmpty), .pauseReq(pauseReq), .macRead(macRead), .txEn(txEn),
    .statVec(statVec), .statEn(statEn), .txDone(txDone), .discardFrame(discardFrame));

// [dv/tmc_client_model.sv]
`timescale 1ns/1ps
// ****************************************
// Client transmit FIFO model
// ****************************************
module tmc_client_model (
    input wire logic clock,
    input wire logic rst,
    input wire logic clockEn,
    input wire logic macRead,
    input wire logic load,
    input wire logic noEof,
    input wire logic [7:0] len,
    output logic [7:0] fifoData,
    output logic fifoEof,
    output logic fifoEmpty,
    output logic fifoAvail
);
    logic [7:0] remain; // Bytes still held
    logic [7:0] idx; // Index of next byte
    // Read port with one cycle latency, like a plain synchronous FIFO
    always_ff @(posedge clock) begin
        if (rst) begin
            remain <= 8'h00;
            idx <= 8'h00;
            fifoData <= 8'h00;
            fifoEof <= 1'b0;
        end else begin
            // Idle bus flips per byte slot so a stale byte can never look valid
            if (clockEn) begin
                fifoEof <= 1'b0;
                fifoData <= ~fifoData;
            end
            if (load) begin
                remain <= len;
                idx <= 8'h00;
            end else if (macRead && remain != 8'h00) begin
                fifoData <= idx ^ 8'h5A;
                fifoEof <= (remain == 8'h01) && !noEof;
                remain <= remain - 8'h01;
                idx <= idx + 8'h01;
            end
        end
    end
    // Flags wired straight from the fill level
    assign fifoEmpty = (remain == 8'h00);
    assign fifoAvail = (remain != 8'h00);
endmodule

// [dv/tmc_tx_client_tb.sv]
`timescale 1ns/1ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin failures++; $display("wrong value at %0t: %h expected %h", $time, a, b); end end
module tmc_tx_client_tb import tmc_pkg::*;;
    // ****************************************
    // Stimulus and observed signals
    // ****************************************
    logic clock = 1'b0, rst = 1'b1, clockEn = 1'b1, halfDuplex = 1'b0, fifoCtrl = 1'b0;
    logic pauseReq = 1'b0, lateCollision = 1'b0, excessCollision = 1'b0, txReady = 1'b1;
    logic load = 1'b0, noEof = 1'b0, seenStat = 1'b0, errSeen = 1'b0, lastDone, lastDisc;
    logic [15:0] pauseTime = 16'h0000;
    logic [7:0] frameLen = 8'h00, fifoData, txData;
    logic fifoAvail, fifoEof, fifoEmpty, macRead, txEn, txErr, statEn, txDone, discardFrame;
    logic [30:0] statVec, lastVec;
    logic [7:0] got [0:127]; // Bytes taken on the network side
    int nGot = 0, failures = 0, checked = 0, div = 1, ceCnt = 0;
    tmc_tx_client dut (.clock(clock), .rst(rst), .clockEn(clockEn), .halfDuplex(halfDuplex),
        .fifoData(fifoData), .fifoAvail(fifoAvail), .fifoEof(fifoEof), .fifoEmpty(fifoEmpty),
        .fifoCtrl(fifoCtrl), .pauseTime(pauseTime), .pauseReq(pauseReq),
        .lateCollision(lateCollision), .excessCollision(excessCollision), .macRead(macRead),
        .txData(txData), .txEn(txEn), .txErr(txErr), .txReady(txReady), .statVec(statVec),
        .statEn(statEn), .txDone(txDone), .discardFrame(discardFrame));
    tmc_client_model client (.clock(clock), .rst(rst), .clockEn(clockEn), .macRead(macRead),
        .load(load),
        .noEof(noEof), .len(frameLen), .fifoData(fifoData), .fifoEof(fifoEof),
        .fifoEmpty(fifoEmpty), .fifoAvail(fifoAvail));
    initial forever #5 clock = ~clock;
    // Clock enable pacing and network side capture
    always @(posedge clock) begin
        ceCnt <= (ceCnt >= div - 1) ? 0 : ceCnt + 1;
        clockEn <= (ceCnt >= div - 1);
        if (txEn && txReady && nGot < 128) begin
            got[nGot] <= txData;
            nGot <= nGot + 1;
            if (txErr) errSeen <= 1'b1;
        end
        if (statEn) begin
            seenStat <= 1'b1;
            lastVec <= statVec;
            lastDone <= txDone;
            lastDisc <= discardFrame;
        end
    end
    // ****************************************
    // Shared tasks
    // ****************************************
    task automatic final_report();
        $display("checked %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    // Loads the model; a cut frame has no end mark and so underruns
    task automatic start(input logic [7:0] len, input logic cut);
        @(posedge clock);
        load <= 1'b1;
        frameLen <= len;
        noEof <= cut;
        nGot <= 0;
        seenStat <= 1'b0;
        errSeen <= 1'b0;
        @(posedge clock);
        load <= 1'b0;
    endtask
    // Bounded wait for statistics, then drain the stage and the gap
    task automatic finish_frame();
        int i;
        for (i = 0; i < 20000 && seenStat !== 1'b1; i++) @(posedge clock);
        if (seenStat !== 1'b1) begin failures++; final_report(); end
        repeat (40 * div) @(posedge clock);
    endtask
    task automatic check_frame(input int n, input logic clean);
        for (int i = 0; i < n; i++) `CHK(got[i], 8'(i) ^ 8'h5A)
        `CHK(lastDone, clean)
        `CHK(lastDisc, !clean)
    endtask
    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_plain();
        for (int k = 0; k < 2; k++) begin
            fifoCtrl <= k[0];
            start(k ? 8'h10 : 8'h01, 1'b0);
            finish_frame();
            check_frame(k ? 16 : 1, 1'b1);
            `CHK(nGot, k ? 16 : 1)
            `CHK(lastVec[21:8], k ? 14'h0010 : 14'h0001)
        end
        fifoCtrl <= 1'b0;
    endtask
    // Stalled network: stage fills and reading stops until released
    task automatic t_stall();
        txReady <= 1'b0;
        start(8'h0C, 1'b0);
        repeat (60) @(posedge clock);
        #1;
        `CHK(macRead, 1'b0)
        `CHK(seenStat, 1'b0)
        @(posedge clock);
        txReady <= 1'b1;
        finish_frame();
        check_frame(12, 1'b1);
    endtask
    task automatic t_underrun();
        start(8'h03, 1'b1);
        finish_frame();
        check_frame(3, 1'b0);
        `CHK(errSeen, 1'b1)
        `CHK(lastVec[TMC_ST_UNDERRUN], 1'b1)
    endtask
    // Time must be taken with the request, not after it drops
    task automatic t_pause();
        logic found;
        found = 1'b0;
        @(posedge clock);
        pauseTime <= 16'h1234;
        pauseReq <= 1'b1;
        nGot <= 0;
        seenStat <= 1'b0;
        @(posedge clock);
        pauseReq <= 1'b0;
        pauseTime <= 16'hFFFF;
        finish_frame();
        `CHK(nGot, 60)
        `CHK(lastVec[TMC_ST_PAUSE], 1'b1)
        for (int i = 0; i < 55; i++)
            if ({got[i], got[i+1], got[i+2], got[i+3], got[i+4], got[i+5]} === 48'h880800011234)
                found = 1'b1;
        `CHK(found, 1'b1)
    endtask
    // Collisions count only in half duplex
    task automatic t_collide();
        for (int k = 0; k < 4; k++) begin
            halfDuplex <= k[1];
            lateCollision <= !k[0];
            excessCollision <= k[0];
            start(8'h04, 1'b0);
            finish_frame();
            check_frame(4, !k[1]);
            `CHK(lastVec[TMC_ST_LATECOL + k[0]], k[1])
        end
        lateCollision <= 1'b0;
        excessCollision <= 1'b0;
        halfDuplex <= 1'b0;
    endtask
    task automatic t_slow();
        div = 10;
        start(8'h05, 1'b0);
        finish_frame();
        check_frame(5, 1'b1);
        div = 1;
    endtask
    // Reset in mid-frame silences the outputs
    task automatic t_reset();
        start(8'h08, 1'b0);
        repeat (12) @(posedge clock);
        rst <= 1'b1;
        repeat (2) @(posedge clock);
        #1;
        `CHK(macRead, 1'b0)
        `CHK(txEn, 1'b0)
        @(posedge clock);
        rst <= 1'b0;
        repeat (20) @(posedge clock);
    endtask
    initial begin
        repeat (16) @(posedge clock);
        rst <= 1'b0;
        t_plain();
        t_stall();
        t_underrun();
        t_pause();
        t_collide();
        t_slow();
        t_reset();
        t_plain();
        final_report();
    end
endmodule
